/* bench/acb_register_bank_chk.sv */
// Port-level assertions for the shadowed config register bank
`timescale 1ns/100ps

module acb_register_bank_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       sclk,
   input wire logic       serial_select_n,
   input wire logic       sdio_i,
   input wire logic       sdio_oe,
   input wire logic [1:0] chan_power_down,
   input wire logic [1:0] chan_standby,
   input wire logic       ext_pin_standby_sel,
   input wire logic       duty_cycle_stabilizer_en,
   input wire logic [3:0] clk_div_ratio,
   input wire logic [7:0] test_mode_a,
   input wire logic [7:0] test_mode_b
);
   // ==========================================================
   // Link-side frame tracking
   // ==========================================================
   logic [6:0]  bit_cnt_reg; // Rising sclk edges in this frame
   logic [15:0] instr_reg;   // Instruction bits, MSB first
   logic [6:0]  data_end;    // Count at which read data stops
   assign data_end = 7'h18 + {2'h0, instr_reg[14:13], 3'h0};

   // A closed frame clears the tracker, as it clears the frame engine
   always_ff @(posedge sclk or posedge serial_select_n) begin
      if (serial_select_n) begin
         bit_cnt_reg <= 7'h00;
         instr_reg   <= 16'h0000;
      end else begin
         // Saturate so an overlong frame cannot wrap to zero
         if (bit_cnt_reg != 7'h7f) begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
         end
         if (bit_cnt_reg < 7'h10) begin
            instr_reg <= {instr_reg[14:0], sdio_i};
         end
      end
   end

   // ==========================================================
   // Link-side assertions
   // ==========================================================
   a_instr_quiet: assert property (@(posedge sclk)
      disable iff (rst || serial_select_n)
      bit_cnt_reg < 7'h10 |-> !sdio_oe) else $error("sdio driven early");
   a_read_drive: assert property (@(posedge sclk)
      disable iff (rst || serial_select_n)
      (bit_cnt_reg >= 7'h10 && bit_cnt_reg < data_end && instr_reg[15])
      |-> sdio_oe) else $error("read data not driven");
   a_write_quiet: assert property (@(posedge sclk)
      disable iff (rst || serial_select_n)
      (bit_cnt_reg >= 7'h10 && !instr_reg[15]) |-> !sdio_oe)
      else $error("sdio driven in write");

   // ==========================================================
   // System clock assertions
   // ==========================================================
   a_idle_release: assert property (@(posedge clk) disable iff (rst)
      serial_select_n [*2] |-> !sdio_oe) else $error("sdio held when idle");
   a_reset_power: assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> chan_power_down == 2'h0 && chan_standby == 2'h0
      && !ext_pin_standby_sel) else $error("power default wrong");
   a_reset_clock: assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> clk_div_ratio == 4'h1 && duty_cycle_stabilizer_en)
      else $error("clock default wrong");
   a_reset_test: assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> test_mode_a == 8'h00 && test_mode_b == 8'h00)
      else $error("test default wrong");
   a_ratio_range: assert property (@(posedge clk) disable iff (rst)
      clk_div_ratio inside {[4'h1:4'h8]}) else $error("ratio out of range");
   a_div_forces_dcs: assert property (@(posedge clk) disable iff (rst)
      clk_div_ratio != 4'h1 |-> duty_cycle_stabilizer_en)
      else $error("stabilizer off while dividing");
   a_mode_exclusive: assert property (@(posedge clk) disable iff (rst)
      (chan_power_down & chan_standby) == 2'h0) else $error("two modes");

   // Main scenarios reached
   c_read: cover property (@(posedge sclk) disable iff (rst) sdio_oe);
   c_standby: cover property (@(posedge clk) disable iff (rst)
      chan_standby != 2'h0);
   c_div8: cover property (@(posedge clk) disable iff (rst)
      clk_div_ratio == 4'h8);
endmodule // acb_register_bank_chk

/* bench/acb_register_bank_tb.sv */
// Self-checking bench for the shadowed config register bank
`timescale 1ns/100ps

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
   bad_count++; $display("wrong value at %0t: got %h expected %h", \
   $time, g, e); end end

module acb_register_bank_tb;
   import acb_pkg::*;
   // ==========================================================
   // Signals and instances
   // ==========================================================
   localparam logic [7:0] TB_ID    = 8'h3c; // Arbitrary identity value
   localparam logic [1:0] TB_GRADE = 2'h2;  // Grade code under test
   // Reset rises on the first falling edge, so the async-cleared link
   // word registers see an edge; no rising clock edge comes before it
   logic        clk = 1'b1, rst = 1'b0;
   logic        sclk, serial_select_n, sdio_m, sdio_o, sdio_oe;
   logic [1:0]  chan_power_down, chan_standby;
   logic        ext_pin_standby_sel, duty_cycle_stabilizer_en;
   logic [3:0]  clk_div_ratio;
   logic [7:0]  test_mode_a, test_mode_b;
   logic [15:0] rdat;      // Data of the last frame, zero after a write
   wire logic   sdio_line; // Resolved level of the two-way pin
   int          bad_count = 0, cmp_count = 0;
   logic [12:0] def_a [7] = '{ADDR_SETUP, ADDR_CHAN_IDX, ADDR_POWER,
                              ADDR_CLK_STAB, ADDR_CLK_DIV, ADDR_TEST,
                              ADDR_XFER};
   logic [7:0]  def_v [7] = '{8'h18, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
   assign sdio_line = sdio_oe ? sdio_o : sdio_m;
   always #5 clk = ~clk;

   acb_register_bank #(.PART_ID(TB_ID), .SPEED_GRADE(TB_GRADE)) dut (
      .clk(clk), .rst(rst), .sclk(sclk), .serial_select_n(serial_select_n),
      .sdio_i(sdio_line), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
      .chan_power_down(chan_power_down), .chan_standby(chan_standby),
      .ext_pin_standby_sel(ext_pin_standby_sel),
      .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en),
      .clk_div_ratio(clk_div_ratio), .test_mode_a(test_mode_a),
      .test_mode_b(test_mode_b));
   acb_serial_master m (.sclk(sclk), .serial_select_n(serial_select_n),
      .sdio_m(sdio_m), .sdio_line(sdio_line));

   // ==========================================================
   // Access tasks
   // ==========================================================
   // One frame, then room for a write to land before anything follows
   task automatic acc(input logic rd, input logic [1:0] len,
                      input logic [12:0] a, input logic [15:0] wd);
      @(negedge clk);
      m.frame(rd, len, a, wd, rdat);
      repeat (10) @(negedge clk);
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      acc(1'b0, 2'h0, a, {8'h00, d});
   endtask
   task automatic xfer();
      wr(ADDR_XFER, 8'h01);
   endtask
   task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
      acc(1'b1, 2'h0, a, 16'h0000);
      `CHK(rdat[7:0], e)
   endtask
   task automatic fin(input string s);
      $display("test %0s done", s);
   endtask
   // Single exit point of the run
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      @(negedge clk);
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      `CHK({chan_power_down, chan_standby, ext_pin_standby_sel}, 5'h00)
      `CHK({duty_cycle_stabilizer_en, clk_div_ratio}, 5'h11)
      `CHK({test_mode_a, test_mode_b}, 16'h0000)
      for (int i = 0; i < 7; i++) begin
         rd_chk(def_a[i], def_v[i]);
      end
      fin("defaults");
      // Divide field held in shadow until the transfer command
      wr(ADDR_CLK_STAB, 8'h00);
      for (int d = 0; d < 8; d++) begin
         wr(ADDR_CLK_DIV, 8'(d));
         `CHK(clk_div_ratio, 4'((d == 0) ? 1 : d))
         xfer();
         `CHK(clk_div_ratio, 4'(d + 1))
         `CHK(duty_cycle_stabilizer_en, d != 0)
      end
      rd_chk(ADDR_XFER, 8'h00);
      fin("shadow and divide");
      // Every power code, both channels selected
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_POWER, {2'h0, c[0], 3'h0, 2'(c)});
         xfer();
         `CHK(chan_power_down, {2{c == 1}})
         `CHK(chan_standby, {2{c == 2}})
         `CHK(ext_pin_standby_sel, c[0])
      end
      fin("power modes");
      // Per-channel copies steered by the index register
      wr(ADDR_CHAN_IDX, 8'h01);
      wr(ADDR_TEST, 8'h25);
      wr(ADDR_CHAN_IDX, 8'h02);
      wr(ADDR_TEST, 8'h0a);
      wr(ADDR_CLK_STAB, 8'h01);
      xfer();
      `CHK(test_mode_a, 8'h25)
      `CHK(test_mode_b, 8'h0a)
      rd_chk(ADDR_TEST, 8'h0a);
      rd_chk(ADDR_CLK_STAB, 8'h01);
      wr(ADDR_CHAN_IDX, 8'h03);
      rd_chk(ADDR_TEST, 8'h25);
      fin("channels");
      // Read-only and unmapped places
      wr(ADDR_PART_ID, 8'h00);
      wr(ADDR_GRADE, 8'hff);
      rd_chk(ADDR_PART_ID, TB_ID);
      rd_chk(ADDR_GRADE, {2'h0, TB_GRADE, 4'h0});
      wr(13'h0003, 8'h5a);
      rd_chk(13'h0003, 8'h00);
      fin("read only");
      // Two-byte frames step the address down
      acc(1'b0, 2'h1, ADDR_TEST, 16'h1122);
      rd_chk(ADDR_TEST, 8'h11);
      acc(1'b1, 2'h1, ADDR_CLK_STAB, 16'h0000);
      `CHK(rdat, 16'h0123)
      fin("multi byte");
      // Soft reset through the mirrored bits reloads shadow and live copies
      wr(ADDR_SETUP, 8'h24);
      rd_chk(ADDR_SETUP, 8'h18);
      rd_chk(ADDR_CLK_DIV, 8'h00);
      `CHK({duty_cycle_stabilizer_en, clk_div_ratio}, 5'h11)
      `CHK({test_mode_a, test_mode_b}, 16'h0000)
      fin("soft reset");
      report_and_stop();
   end
endmodule // acb_register_bank_tb

bind acb_register_bank acb_register_bank_chk u_chk (
   .clk(clk), .rst(rst), .sclk(sclk), .serial_select_n(serial_select_n),
   .sdio_i(sdio_i), .sdio_oe(sdio_oe), .chan_power_down(chan_power_down),
   .chan_standby(chan_standby), .ext_pin_standby_sel(ext_pin_standby_sel),
   .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en),
   .clk_div_ratio(clk_div_ratio), .test_mode_a(test_mode_a),
   .test_mode_b(test_mode_b));

/* bench/acb_serial_master.sv */
// Serial port master model that frames register accesses
`timescale 1ns/100ps

module acb_serial_master #(
   parameter int HALF = 24 // Half link clock period in ns
) (
   output logic      sclk,
   output logic      serial_select_n,
   output logic      sdio_m,
   input  wire logic sdio_line
);
   // Link clock stands still and select rests high between frames; the
   // select rises a moment after start so the frame logic's async clear
   // sees a real edge instead of racing the start of its process
   initial begin
      sclk            = 1'b0;
      serial_select_n = 1'b0;
      sdio_m          = 1'b0;
      #1 serial_select_n = 1'b1;
   end

   // One link clock period, data set up half a period before the rise
   task automatic send_bit(input logic b);
      sdio_m = b;
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
   endtask

   // Instruction word, then len+1 whole bytes, all MSB first
   task automatic frame(input logic rd, input logic [1:0] len,
                        input logic [12:0] addr, input logic [15:0] wd,
                        output logic [15:0] rdat);
      logic [15:0] instr;
      int          nbits;
      instr           = {rd, len, addr};
      nbits           = 8 * (int'(len) + 1);
      rdat            = 16'h0000;
      serial_select_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         send_bit(instr[i]);
      end
      for (int i = nbits - 1; i >= 0; i--) begin
         if (rd) begin
            // Released line: a changing pattern, never the last bit
            sdio_m = ~sdio_m;
            #HALF sclk = 1'b1;
            rdat = {rdat[14:0], sdio_line};
            #HALF sclk = 1'b0;
         end else begin
            send_bit(wd[i]);
         end
      end
      #HALF serial_select_n = 1'b1;
      sdio_m = ~sdio_m;
   endtask
endmodule // acb_serial_master

/* core/acb_pkg.sv */
// Package of addresses, field positions and reset values for the config bank
package acb_pkg;

   // ==========================================================
   // Serial frame layout
   // ==========================================================
   localparam int         ADDR_W       = 13;   // Address width in instruction
   localparam int         INSTR_BITS   = 16;   // Instruction phase length
   localparam int         INSTR_RW_BIT = 15;   // 1 = read, 0 = write
   localparam int         INSTR_LEN_HI = 14;   // Transfer length field, high
   localparam int         INSTR_LEN_LO = 13;   // Transfer length field, low
   localparam logic [3:0] INSTR_LAST   = 4'hf; // Count at last instruction bit
   localparam logic [2:0] BYTE_LAST    = 3'h7; // Bit index of last data bit

   // ==========================================================
   // Register addresses
   // ==========================================================
   localparam logic [12:0] ADDR_SETUP     = 13'h0000;
   localparam logic [12:0] ADDR_PART_ID   = 13'h0001;
   localparam logic [12:0] ADDR_GRADE     = 13'h0002;
   localparam logic [12:0] ADDR_CHAN_IDX  = 13'h0005;
   localparam logic [12:0] ADDR_POWER     = 13'h0008;
   localparam logic [12:0] ADDR_CLK_STAB  = 13'h0009;
   localparam logic [12:0] ADDR_CLK_DIV   = 13'h000b;
   localparam logic [12:0] ADDR_TEST      = 13'h000d;
   localparam logic [12:0] ADDR_XFER      = 13'h00ff;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] RST_SETUP    = 8'h18;
   localparam logic [1:0] RST_CHAN_IDX = 2'h3;
   localparam logic [1:0] RST_PMODE    = 2'h0;
   localparam logic       RST_EXT_PIN  = 1'b0;
   localparam logic       RST_DCS      = 1'b1;
   localparam logic [2:0] RST_DIV      = 3'h0;
   localparam logic [7:0] RST_TEST     = 8'h00;

   // ==========================================================
   // Field positions and masks
   // ==========================================================
   localparam int         SOFT_RST_HI  = 5;     // Mirrored soft reset bits
   localparam int         SOFT_RST_LO  = 2;
   localparam int         CHAN_A_BIT   = 0;
   localparam int         CHAN_B_BIT   = 1;
   localparam int         EXT_PIN_BIT  = 5;     // Power-down pin meaning
   localparam int         DCS_BIT      = 0;
   localparam int         XFER_BIT     = 0;
   localparam int         GRADE_LSB    = 4;
   localparam logic [7:0] TEST_MASK    = 8'h3f; // Writable test mode bits

   // ==========================================================
   // Internal power mode codes
   // ==========================================================
   localparam logic [1:0] PMODE_DOWN    = 2'h1;
   localparam logic [1:0] PMODE_STANDBY = 2'h2;

endpackage

/* core/acb_register_bank.sv */
// Shadowed configuration register bank with its serial port front end
// Function
// - 0x08..0x0D writes held in shadow storage
// - Writing 0x01 to 0xFF applies shadows together
// - Transfer bit clears itself after the update
// - Reset loads every register default
// - Local registers per channel, chosen by 0x05
// - Both selects set: write both channel copies
// - Both selects set on read: return channel A
// - Global registers ignore channel select bits
// - Unmapped addresses and bits have no function
// - Power code 01 down, 10 standby, else normal
// - Frame: 16-bit instruction then 8-bit data words
// - Length field plus one gives byte count
`timescale 1ns/100ps

module acb_register_bank
   import acb_pkg::*;
#(
   parameter logic [7:0] PART_ID     = 8'h5a, // Arbitrary identity value
   parameter logic [1:0] SPEED_GRADE = 2'h0   // Speed grade code
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclk,
   input  wire logic       serial_select_n,
   input  wire logic       sdio_i,
   output logic            sdio_o,
   output logic            sdio_oe,
   output logic [1:0]      chan_power_down,
   output logic [1:0]      chan_standby,
   output logic            ext_pin_standby_sel,
   output logic            duty_cycle_stabilizer_en,
   output logic [3:0]      clk_div_ratio,
   output logic [7:0]      test_mode_a,
   output logic [7:0]      test_mode_b
);

   // ==========================================================
   // Link side state (sclk domain)
   // ==========================================================
   logic [15:0]       shift_reg;       // Incoming bit shifter
   logic [3:0]        bit_cnt_reg;     // Instruction bit count
   logic              instr_done_reg;  // Instruction phase complete
   logic              rw_reg;          // Frame is a read
   logic [2:0]        bytes_left_reg;  // Data bytes still to move
   logic [2:0]        byte_bit_reg;    // Bit index inside a data byte
   logic [ADDR_W-1:0] cur_addr_reg;    // Address of current data byte
   logic [ADDR_W-1:0] link_wr_addr_reg; // Write word handed across
   logic [7:0]        link_wr_data_reg;
   logic              link_wr_tgl_reg; // Flips once per written byte
   logic [7:0]        rd_shift_reg;    // Outgoing read bits
   logic              sdio_o_reg;
   logic              sdio_oe_reg;

   // ==========================================================
   // Register side state (clk domain)
   // ==========================================================
   logic [7:0] setup_reg;              // Port setup, soft reset self-clears
   logic [1:0] chan_idx_reg;           // Channel B / A select bits
   logic       xfer_reg;               // Transfer command bit
   logic       wr_sync1_reg;           // Toggle synchroniser, first stage
   logic       wr_sync2_reg;
   logic       wr_sync3_reg;           // Edge detect history
   logic [1:0] sh_pmode_reg [0:1];     // Shadow copies, per channel
   logic [7:0] sh_test_reg  [0:1];
   logic       sh_ext_reg;             // Shadow copies, global
   logic       sh_dcs_reg;
   logic [2:0] sh_div_reg;
   logic [1:0] lv_pmode_reg [0:1];     // Live copies that steer the part
   logic [7:0] lv_test_reg  [0:1];
   logic       lv_ext_reg;
   logic       lv_dcs_reg;
   logic [2:0] lv_div_reg;
   logic [1:0] pdown_reg;              // Registered outputs
   logic [1:0] stby_reg;
   logic       ext_out_reg;
   logic       dcs_out_reg;
   logic [3:0] ratio_reg;
   logic [7:0] test_a_reg;
   logic [7:0] test_b_reg;

   // ==========================================================
   // Link side decoding
   // ==========================================================
   wire logic [15:0] shift_next = {shift_reg[14:0], sdio_i};
   wire logic        data_act   = instr_done_reg && (bytes_left_reg != 3'h0);
   wire logic        byte_end   = data_act && (byte_bit_reg == BYTE_LAST);
   wire logic [2:0]  len_bytes  =
      3'({1'b0, shift_next[INSTR_LEN_HI:INSTR_LEN_LO]}) + 3'h1;
   wire logic [ADDR_W-1:0] addr_dec = cur_addr_reg - 13'h0001;

   // Frame sequencer; a high select ends the frame at once, since the
   // link clock may stop right after the last bit
   always_ff @(posedge sclk or posedge serial_select_n) begin
      if (serial_select_n) begin
         shift_reg      <= 16'h0000;
         bit_cnt_reg    <= 4'h0;
         instr_done_reg <= 1'b0;
         rw_reg         <= 1'b0;
         bytes_left_reg <= 3'h0;
         byte_bit_reg   <= 3'h0;
         cur_addr_reg   <= 13'h0000;
      end else if (!instr_done_reg) begin
         // Instruction phase collects sixteen bits
         shift_reg   <= shift_next;
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         if (bit_cnt_reg == INSTR_LAST) begin
            instr_done_reg <= 1'b1;
            rw_reg         <= shift_next[INSTR_RW_BIT];
            bytes_left_reg <= len_bytes;
            cur_addr_reg   <= shift_next[ADDR_W-1:0];
         end
      end else if (data_act) begin
         // Data phase: 8-bit words, address steps down per word
         shift_reg    <= shift_next;
         byte_bit_reg <= byte_bit_reg + 3'h1;
         if (byte_end) begin
            bytes_left_reg <= bytes_left_reg - 3'h1;
            cur_addr_reg   <= addr_dec;
         end
      end
   end

   // Written words outlive the frame so the register side can take them
   // after the select rises; only the system reset clears them
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         link_wr_addr_reg <= 13'h0000;
         link_wr_data_reg <= 8'h00;
         link_wr_tgl_reg  <= 1'b0;
      end else if (byte_end && !rw_reg) begin
         link_wr_addr_reg <= cur_addr_reg;
         link_wr_data_reg <= shift_next[7:0];
         link_wr_tgl_reg  <= ~link_wr_tgl_reg;
      end
   end

   // ==========================================================
   // Read multiplexer
   // ==========================================================
   // Register contents change only through link writes, soft reset and
   // transfer, none of which can happen inside a read frame, so the link
   // samples this mux directly; a write must settle before the next read
   wire logic       rd_sel_b = chan_idx_reg[CHAN_B_BIT] &&
                               !chan_idx_reg[CHAN_A_BIT];
   wire logic [1:0] rd_pmode = rd_sel_b ? sh_pmode_reg[1] : sh_pmode_reg[0];
   wire logic [7:0] rd_test  = rd_sel_b ? sh_test_reg[1]  : sh_test_reg[0];
   wire logic [7:0] rd_byte  =
      (cur_addr_reg == ADDR_SETUP)    ? setup_reg :
      (cur_addr_reg == ADDR_PART_ID)  ? PART_ID :
      (cur_addr_reg == ADDR_GRADE)    ? 8'(SPEED_GRADE) << GRADE_LSB :
      (cur_addr_reg == ADDR_CHAN_IDX) ? {6'h00, chan_idx_reg} :
      (cur_addr_reg == ADDR_XFER)     ? {7'h00, xfer_reg} :
      (cur_addr_reg == ADDR_POWER)    ?
         {2'h0, sh_ext_reg, 3'h0, rd_pmode} :
      (cur_addr_reg == ADDR_CLK_STAB) ? {7'h00, sh_dcs_reg} :
      (cur_addr_reg == ADDR_CLK_DIV)  ? {5'h00, sh_div_reg} :
      (cur_addr_reg == ADDR_TEST)     ? rd_test :
      8'h00;

   // Read bits leave on the falling edge, a half period ahead of the
   // master's sampling edge
   always_ff @(negedge sclk or posedge serial_select_n) begin
      if (serial_select_n) begin
         rd_shift_reg <= 8'h00;
         sdio_o_reg   <= 1'b0;
         sdio_oe_reg  <= 1'b0;
      end else if (data_act && rw_reg) begin
         sdio_oe_reg <= 1'b1;
         if (byte_bit_reg == 3'h0) begin
            sdio_o_reg   <= rd_byte[7];
            rd_shift_reg <= {rd_byte[6:0], 1'b0};
         end else begin
            sdio_o_reg   <= rd_shift_reg[7];
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
         end
      end else begin
         sdio_oe_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Write word crossing into clk
   // ==========================================================
   // Toggle synchroniser; the word itself stays still for eight link
   // clocks, far longer than the three-cycle sync latency
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_sync1_reg <= 1'b0;
         wr_sync2_reg <= 1'b0;
         wr_sync3_reg <= 1'b0;
      end else begin
         wr_sync1_reg <= link_wr_tgl_reg;
         wr_sync2_reg <= wr_sync1_reg;
         wr_sync3_reg <= wr_sync2_reg;
      end
   end

   // ==========================================================
   // Write decoding
   // ==========================================================
   wire logic       wr_pulse  = wr_sync2_reg ^ wr_sync3_reg;
   wire logic [7:0] wd        = link_wr_data_reg;
   wire logic       wr_setup  = wr_pulse && (link_wr_addr_reg == ADDR_SETUP);
   wire logic       wr_idx    = wr_pulse &&
                                (link_wr_addr_reg == ADDR_CHAN_IDX);
   wire logic       wr_xfer   = wr_pulse && (link_wr_addr_reg == ADDR_XFER);
   wire logic       wr_power  = wr_pulse && (link_wr_addr_reg == ADDR_POWER);
   wire logic       wr_stab   = wr_pulse &&
                                (link_wr_addr_reg == ADDR_CLK_STAB);
   wire logic       wr_div    = wr_pulse && (link_wr_addr_reg == ADDR_CLK_DIV);
   wire logic       wr_test   = wr_pulse && (link_wr_addr_reg == ADDR_TEST);
   wire logic       soft_rst  = wr_setup &&
                                (wd[SOFT_RST_HI] || wd[SOFT_RST_LO]);
   wire logic       init      = rst || soft_rst;
   wire logic       xfer_cmd  = wr_xfer && wd[XFER_BIT];

   // Chip setup, channel index and transfer bit; identity and grade
   // registers have no storage, so writes to them fall away
   always_ff @(posedge clk) begin
      if (init) begin
         setup_reg    <= RST_SETUP;
         chan_idx_reg <= RST_CHAN_IDX;
         xfer_reg     <= 1'b0;
      end else begin
         if (wr_setup) begin
            setup_reg <= wd;
         end
         if (wr_idx) begin
            chan_idx_reg <= wd[1:0];
         end
         // A new command in the cycle of the clear still sets the bit
         xfer_reg <= xfer_cmd;
      end
   end

   // Shadow storage; local fields go to each selected channel copy
   always_ff @(posedge clk) begin
      if (init) begin
         sh_ext_reg <= RST_EXT_PIN;
         sh_dcs_reg <= RST_DCS;
         sh_div_reg <= RST_DIV;
         for (int i = 0; i < 2; i++) begin
            sh_pmode_reg[i] <= RST_PMODE;
            sh_test_reg[i]  <= RST_TEST;
         end
      end else begin
         if (wr_power) begin
            sh_ext_reg <= wd[EXT_PIN_BIT];
         end
         if (wr_stab) begin
            sh_dcs_reg <= wd[DCS_BIT];
         end
         if (wr_div) begin
            sh_div_reg <= wd[2:0];
         end
         for (int i = 0; i < 2; i++) begin
            if (wr_power && chan_idx_reg[i]) begin
               sh_pmode_reg[i] <= wd[1:0];
            end
            if (wr_test && chan_idx_reg[i]) begin
               sh_test_reg[i] <= wd & TEST_MASK;
            end
         end
      end
   end

   // Live copies move all at once on the transfer bit
   always_ff @(posedge clk) begin
      if (init) begin
         lv_ext_reg <= RST_EXT_PIN;
         lv_dcs_reg <= RST_DCS;
         lv_div_reg <= RST_DIV;
         for (int i = 0; i < 2; i++) begin
            lv_pmode_reg[i] <= RST_PMODE;
            lv_test_reg[i]  <= RST_TEST;
         end
      end else if (xfer_reg) begin
         lv_ext_reg <= sh_ext_reg;
         lv_dcs_reg <= sh_dcs_reg;
         lv_div_reg <= sh_div_reg;
         for (int i = 0; i < 2; i++) begin
            lv_pmode_reg[i] <= sh_pmode_reg[i];
            lv_test_reg[i]  <= sh_test_reg[i];
         end
      end
   end

   // ==========================================================
   // Decoded controls
   // ==========================================================
   // Registered so the converter sees clean levels, one cycle after live
   always_ff @(posedge clk) begin
      if (rst) begin
         pdown_reg   <= 2'h0;
         stby_reg    <= 2'h0;
         ext_out_reg <= RST_EXT_PIN;
         dcs_out_reg <= RST_DCS;
         ratio_reg   <= 4'h1;
         test_a_reg  <= RST_TEST;
         test_b_reg  <= RST_TEST;
      end else begin
         for (int i = 0; i < 2; i++) begin
            pdown_reg[i] <= (lv_pmode_reg[i] == PMODE_DOWN);
            stby_reg[i]  <= (lv_pmode_reg[i] == PMODE_STANDBY);
         end
         ext_out_reg <= lv_ext_reg;
         dcs_out_reg <= lv_dcs_reg || (lv_div_reg != 3'h0);
         ratio_reg   <= {1'b0, lv_div_reg} + 4'h1;
         test_a_reg  <= lv_test_reg[0];
         test_b_reg  <= lv_test_reg[1];
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign sdio_o                   = sdio_o_reg;
   assign sdio_oe                  = sdio_oe_reg;
   assign chan_power_down          = pdown_reg;
   assign chan_standby             = stby_reg;
   assign ext_pin_standby_sel      = ext_out_reg;
   assign duty_cycle_stabilizer_en = dcs_out_reg;
   assign clk_div_ratio            = ratio_reg;
   assign test_mode_a              = test_a_reg;
   assign test_mode_b              = test_b_reg;

endmodule // acb_register_bank
